/* hw/dbgh_host.sv */
// How it works
// - wait 150 bus cycles before reading data
// - wait 150 bus cycles after write data
// - wait 44 cycles before firmware read data
// - wait 32 cycles after firmware write data
// - wait 64 cycles after step or go
// - acknowledge pulse may end waits early
// - each command byte is eight bit times, idle high
// - host opens every bit with falling edge
// - msb first, sixteen target cycles per bit
// - open-drain line, drivers pull low except the speed-up pulse
// - brief driven-high speed-up pulse restores one
`timescale 1ns/1ps
module dbgh_host (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire dbgh_pkg::dbgh_kind_t cmd_kind,
	input wire logic [7:0] cmd_opcode,
	input wire logic [15:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic ack_enable,
	input wire logic special_mode,
	input wire logic tgt_reset_n,
	output logic resp_valid,
	output logic [15:0] resp_data,
	input wire logic debug_serial_pin_in,
	output logic debug_serial_pin_out,
	output logic debug_serial_pin_oe
);
	import dbgh_pkg::*;

	typedef enum {L_IDLE, L_TX, L_MID, L_RX, L_POST} dbgh_link_t;

	dbgh_bit_if bus();

	////////////////////////////////////////////////////////////////////////
	// system side: accept a command, wait for the link to finish
	dbgh_kind_t h_kind, next_h_kind;
	logic [7:0] h_op, next_h_op;
	logic [15:0] h_addr, next_h_addr;
	logic [15:0] h_data, next_h_data;
	logic req_tgl, next_req_tgl;
	logic next_cmd_ready, next_resp_valid;
	logic [15:0] next_resp_data;
	logic dn_s1, dn_s2, dn_s3;
	logic done_tgl;
	logic [15:0] rdata;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dn_s1 <= 1'b0;
			dn_s2 <= 1'b0;
			dn_s3 <= 1'b0;
		end else begin
			dn_s1 <= done_tgl;
			dn_s2 <= dn_s1;
			dn_s3 <= dn_s2;
		end
	end

	always_comb begin
		next_h_kind = h_kind;
		next_h_op = h_op;
		next_h_addr = h_addr;
		next_h_data = h_data;
		next_req_tgl = req_tgl;
		next_cmd_ready = cmd_ready;
		next_resp_valid = 1'b0;
		next_resp_data = resp_data;
		if (cmd_valid && cmd_ready) begin
			next_h_kind = cmd_kind;
			next_h_op = cmd_opcode;
			// words always go out even-aligned
			next_h_addr = {cmd_addr[15:1], 1'b0};
			next_h_data = cmd_wdata;
			next_req_tgl = !req_tgl;
			next_cmd_ready = 1'b0;
		end
		// rdata is stable here: the link updated it before toggling
		if (dn_s2 != dn_s3) begin
			next_resp_valid = 1'b1;
			next_resp_data = rdata;
			next_cmd_ready = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			h_kind <= K_HW_READ;
			h_op <= 8'h00;
			h_addr <= 16'h0000;
			h_data <= 16'h0000;
			req_tgl <= 1'b0;
			cmd_ready <= 1'b1;
			resp_valid <= 1'b0;
			resp_data <= 16'h0000;
		end else begin
			h_kind <= next_h_kind;
			h_op <= next_h_op;
			h_addr <= next_h_addr;
			h_data <= next_h_data;
			req_tgl <= next_req_tgl;
			cmd_ready <= next_cmd_ready;
			resp_valid <= next_resp_valid;
			resp_data <= next_resp_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side synchronisers: request toggle and slow levels
	logic rq_s1, rq_s2, rq_s3;
	logic ak_s1, ak_s2;
	logic sp_s1, sp_s2;
	logic tr_s1, tr_s2;

	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			rq_s1 <= 1'b0;
			rq_s2 <= 1'b0;
			rq_s3 <= 1'b0;
			ak_s1 <= 1'b0;
			ak_s2 <= 1'b0;
			sp_s1 <= 1'b0;
			sp_s2 <= 1'b0;
			tr_s1 <= 1'b1;
			tr_s2 <= 1'b1;
		end else begin
			rq_s1 <= req_tgl;
			rq_s2 <= rq_s1;
			rq_s3 <= rq_s2;
			ak_s1 <= ack_enable;
			ak_s2 <= ak_s1;
			sp_s1 <= special_mode;
			sp_s2 <= sp_s1;
			tr_s1 <= tgt_reset_n;
			tr_s2 <= tr_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link sequencer: opcode, address, data bytes and the waits between
	dbgh_link_t lst, next_lst;
	logic [TXBUF_W-1:0] txbuf, next_txbuf;
	logic [LEFT_W-1:0] tx_left, next_tx_left;
	logic [LEFT_W-1:0] rx_left, next_rx_left;
	logic [WAIT_W-1:0] wcnt, next_wcnt;
	logic [WAIT_W-1:0] post, next_post;
	logic [WAIT_W-1:0] mid, next_mid;
	logic start, next_start;
	logic tx, next_tx;
	logic hold, next_hold;
	logic next_done_tgl;
	logic [15:0] next_rdata;
	logic line_q;
	logic ack_seen;

	// the target answers an enabled acknowledge with a low pulse
	assign ack_seen = ak_s2 && line_q && !bus.line_high;

	always_comb begin
		next_lst = lst;
		next_txbuf = txbuf;
		next_tx_left = tx_left;
		next_rx_left = rx_left;
		next_wcnt = wcnt;
		next_post = post;
		next_mid = mid;
		next_start = 1'b0;
		next_tx = tx;
		next_done_tgl = done_tgl;
		next_rdata = rdata;
		// mode-select strap: hold low while the target is in reset and special_mode is set
		next_hold = (lst == L_IDLE) && !tr_s2 && sp_s2;
		unique case (lst)
			L_IDLE: begin
				if (rq_s2 != rq_s3 && tr_s2) begin
					next_lst = L_TX;
					next_start = 1'b1;
					next_tx = 1'b1;
					next_rx_left = '0;
					next_mid = '0;
					next_post = '0;
					unique case (h_kind)
						K_HW_READ: begin
							next_txbuf = {h_op, h_addr, 16'h0000};
							next_tx_left = TX_HW_RD;
							next_rx_left = RX_WORD;
							// covers the device's cycle steal
							next_mid = WAIT_W'(WAIT_HW_RD);
						end
						K_HW_WRITE: begin
							next_txbuf = {h_op, h_addr, h_data};
							next_tx_left = TX_HW_WR;
							next_post = WAIT_W'(WAIT_HW_WR);
						end
						K_FW_READ: begin
							next_txbuf = {h_op, 32'h00000000};
							next_tx_left = TX_FW_RD;
							next_rx_left = RX_WORD;
							// includes external access penalty
							next_mid = WAIT_W'(WAIT_FW_RD);
						end
						K_FW_WRITE: begin
							next_txbuf = {h_op, h_data, 16'h0000};
							next_tx_left = TX_FW_WR;
							next_post = WAIT_W'(WAIT_FW_WR);
						end
						K_FW_CTRL: begin
							next_txbuf = {h_op, 32'h00000000};
							next_tx_left = TX_CTRL;
							next_post = WAIT_W'(WAIT_GO);
						end
					endcase
				end
			end
			L_TX: begin
				if (bus.done) begin
					// bytes follow back to back, far inside the timeout
					if (tx_left == LEFT_W'(1)) begin
						next_tx = 1'b0;
						if (rx_left != '0) begin
							next_lst = L_MID;
							next_wcnt = mid;
						end else begin
							next_lst = L_POST;
							next_wcnt = post;
						end
					end else begin
						next_tx_left = tx_left - 1'b1;
						next_txbuf = {txbuf[TXBUF_W-9:0], 8'h00};
						next_start = 1'b1;
					end
				end
			end
			L_MID: begin
				if (wcnt == '0 || ack_seen) begin
					next_lst = L_RX;
					next_start = 1'b1;
				end else begin
					next_wcnt = wcnt - 1'b1;
				end
			end
			L_RX: begin
				if (bus.done) begin
					next_rdata = {rdata[7:0], bus.rx_byte};
					next_rx_left = rx_left - 1'b1;
					if (rx_left == LEFT_W'(1)) begin
						next_lst = L_POST;
						next_wcnt = post;
					end else begin
						next_start = 1'b1;
					end
				end
			end
			L_POST: begin
				if (wcnt == '0 || ack_seen) begin
					next_lst = L_IDLE;
					next_done_tgl = !done_tgl;
				end else begin
					next_wcnt = wcnt - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			lst <= L_IDLE;
			txbuf <= '0;
			tx_left <= '0;
			rx_left <= '0;
			wcnt <= '0;
			post <= '0;
			mid <= '0;
			start <= 1'b0;
			tx <= 1'b0;
			hold <= 1'b0;
			done_tgl <= 1'b0;
			rdata <= 16'h0000;
			line_q <= 1'b1;
		end else begin
			lst <= next_lst;
			txbuf <= next_txbuf;
			tx_left <= next_tx_left;
			rx_left <= next_rx_left;
			wcnt <= next_wcnt;
			post <= next_post;
			mid <= next_mid;
			start <= next_start;
			tx <= next_tx;
			hold <= next_hold;
			done_tgl <= next_done_tgl;
			rdata <= next_rdata;
			line_q <= bus.line_high;
		end
	end

	assign bus.start = start;
	assign bus.tx = tx;
	assign bus.hold_low = hold;
	assign bus.tx_byte = txbuf[TXBUF_W-1:TXBUF_W-8];

	////////////////////////////////////////////////////////////////////////
	// link clock is the target's selected serial clock
	dbgh_bit_engine u_engine (
		.clk_link(clk_link),
		.resetn(resetn),
		.bus(bus),
		.pin_in(debug_serial_pin_in),
		.pin_out(debug_serial_pin_out),
		.pin_oe(debug_serial_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_link); endclocking
	default disable iff (!resetn);
	a_no_cmd_in_wait: assert property (
		(lst == L_POST) |-> !bus.start)
		else $error("new byte started during post-command wait");
	a_hw_read_wait: assert property (
		(lst == L_TX && bus.done && tx_left == 1 && h_kind == K_HW_READ)
		|=> (lst == L_MID && wcnt == 8'h96))
		else $error("hardware read wait not loaded with 150");
	a_fw_read_wait: assert property (
		(lst == L_TX && bus.done && tx_left == 1 && h_kind == K_FW_READ)
		|=> (lst == L_MID && wcnt == 8'h2c))
		else $error("firmware read wait not loaded with 44");
	a_fw_write_wait: assert property (
		(lst == L_TX && bus.done && tx_left == 1 && h_kind == K_FW_WRITE)
		|=> (lst == L_POST && wcnt == 8'h20))
		else $error("firmware write wait not loaded with 32");
	a_go_wait: assert property (
		(lst == L_TX && bus.done && tx_left == 1 && h_kind == K_FW_CTRL)
		|=> (lst == L_POST && wcnt == 8'h40))
		else $error("step or go wait not loaded with 64");
	a_wait_holds: assert property (
		(lst == L_MID && wcnt != 0 && !ack_seen) |=> (lst == L_MID && !bus.start))
		else $error("read wait ended early without acknowledge");
endmodule // dbgh_host

/* hw/dbgh_pkg.sv */
package dbgh_pkg;
	////////////////////////////////////////////////////////////////////////
	// serial bit timing, in link (target) clock cycles
	localparam int BIT_CYCLES = 16;
	localparam int BITS_PER_BYTE = 8;
	localparam int LOW_ONE = 4;
	localparam int LOW_ZERO = 13;
	localparam int SAMPLE_AT = 12;
	localparam int TIMEOUT_CYCLES = 512;
	localparam int CNT_W = 4;
	localparam int BITN_W = 3;
	////////////////////////////////////////////////////////////////////////
	// waits after commands, in bus clock cycles
	localparam int WAIT_HW_RD = 150;
	localparam int WAIT_HW_WR = 150;
	localparam int WAIT_FW_RD = 44;
	localparam int WAIT_FW_WR = 32;
	localparam int WAIT_GO = 64;
	localparam int WAIT_W = 8;
	////////////////////////////////////////////////////////////////////////
	// command frame layout
	localparam int TXBUF_W = 40;
	localparam int LEFT_W = 3;
	localparam logic [LEFT_W-1:0] TX_HW_RD = 3'h3;
	localparam logic [LEFT_W-1:0] TX_HW_WR = 3'h5;
	localparam logic [LEFT_W-1:0] TX_FW_RD = 3'h1;
	localparam logic [LEFT_W-1:0] TX_FW_WR = 3'h3;
	localparam logic [LEFT_W-1:0] TX_CTRL = 3'h1;
	localparam logic [LEFT_W-1:0] RX_WORD = 3'h2;

	typedef enum logic [2:0] {
		K_HW_READ,
		K_HW_WRITE,
		K_FW_READ,
		K_FW_WRITE,
		K_FW_CTRL
	} dbgh_kind_t;
endpackage

/* hw/dbgh_bit_if.sv */
`timescale 1ns/1ps
interface dbgh_bit_if;
	logic start;
	logic tx;
	logic hold_low;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic done;
	logic line_high;

	modport eng(input start, input tx, input hold_low, input tx_byte,
		output rx_byte, output done, output line_high);
	modport seq(output start, output tx, output hold_low, output tx_byte,
		input rx_byte, input done, input line_high);
endinterface

/* hw/dbgh_bit_engine.sv */
`timescale 1ns/1ps
module dbgh_bit_engine (
	input wire logic clk_link,
	input wire logic resetn,
	dbgh_bit_if.eng bus,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe
);
	import dbgh_pkg::*;

	typedef enum {E_IDLE, E_RUN} dbgh_eng_t;

	dbgh_eng_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [BITN_W-1:0] bitn, next_bitn;
	logic [7:0] sh, next_sh;
	logic tx_mode, next_tx_mode;
	logic done, next_done;
	logic next_pin_out, next_pin_oe;
	logic sync1, sync2;
	logic [CNT_W-1:0] low_len;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser; only the second stage is read
	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bitn = bitn;
		next_sh = sh;
		next_tx_mode = tx_mode;
		next_done = 1'b0;
		next_pin_out = 1'b0;
		next_pin_oe = 1'b0;
		// a one stays low briefly, a zero most of the bit
		if (tx_mode && !sh[7])
			low_len = CNT_W'(LOW_ZERO);
		else
			low_len = CNT_W'(LOW_ONE);
		unique case (state)
			E_IDLE: begin
				next_pin_oe = bus.hold_low;
				if (bus.start) begin
					next_state = E_RUN;
					next_cnt = '0;
					next_bitn = '0;
					next_sh = bus.tx_byte;
					next_tx_mode = bus.tx;
				end
			end
			E_RUN: begin
				// every bit opens with our falling edge
				next_pin_oe = (cnt < low_len) || (tx_mode && cnt == low_len);
				// short driven-high speed-up, then release
				next_pin_out = tx_mode && cnt == low_len;
				// sample late: target answers after our edge
				if (!tx_mode && cnt == CNT_W'(SAMPLE_AT))
					next_sh = {sh[6:0], sync2};
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(BIT_CYCLES - 1)) begin
					if (tx_mode)
						next_sh = {sh[6:0], 1'b0};
					if (bitn == BITN_W'(BITS_PER_BYTE - 1)) begin
						next_state = E_IDLE;
						next_done = 1'b1;
					end else begin
						next_bitn = bitn + 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			state <= E_IDLE;
			cnt <= '0;
			bitn <= '0;
			sh <= '0;
			tx_mode <= 1'b0;
			done <= 1'b0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bitn <= next_bitn;
			sh <= next_sh;
			tx_mode <= next_tx_mode;
			done <= next_done;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	assign bus.done = done;
	assign bus.rx_byte = sh;
	assign bus.line_high = sync2;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_link); endclocking
	default disable iff (!resetn);

	sequence s_one_low;
		(pin_oe && !pin_out) [*4];
	endsequence

	sequence s_speedup_release;
		(pin_oe && pin_out) ##1 !pin_oe;
	endsequence

	a_edge_opens_bit: assert property (
		(state == E_RUN && cnt == 0) |=> (pin_oe && !pin_out))
		else $error("bit time did not open with a low drive");
	a_byte_eight_bits: assert property (
		(state == E_IDLE && bus.start) |-> ##129 done)
		else $error("byte did not take eight bit times");
	a_high_is_brief: assert property (
		(pin_oe && pin_out) |=> !pin_oe)
		else $error("line held high longer than one cycle");
	a_one_bit_shape: assert property (
		(state == E_RUN && cnt == 0 && tx_mode && sh[7])
		|=> s_one_low ##1 s_speedup_release)
		else $error("one bit lacks low phase or speed-up pulse");
	a_msb_first_out: assert property (
		(state == E_RUN && tx_mode && cnt == 15 && bitn != 7)
		|=> sh == ($past(sh) << 1))
		else $error("transmit shift is not msb first");
endmodule // dbgh_bit_engine

/* verification/dbgh_dev_model.sv */
`timescale 1ns/1ps
module dbgh_dev_model (
	input wire logic clk_link,
	input wire logic tgt_reset_n,
	input wire logic ack_enable,
	input wire logic line,
	output logic drive_low,
	output logic drive_high,
	output logic mode_special,
	output int wait_errs
);
	import dbgh_pkg::*;
	// opcode bits are arbitrary: [7:6] 11 hw, 10 fw data, else control
	logic [15:0] mem [256];
	logic [15:0] fw_word, txw;
	logic [31:0] col, cn;
	logic [7:0] op, ov, sh, b;
	logic line_q, txa, txb, rdw, acked;
	int since, bitn, nin, txn, need, ackc, tot;
	// own low drive is not a host edge
	wire fall = line_q && !line && !drive_low;
	initial begin
		wait_errs = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_link) begin
		line_q <= line;
		if (!tgt_reset_n) begin
			mode_special <= !line;
			drive_low <= 1'b0;
			drive_high <= 1'b0;
			txa <= 1'b0;
			rdw <= 1'b0;
			since <= 0;
			bitn <= 0;
			nin <= 0;
			txn <= 0;
			need <= 0;
			ackc <= 0;
		end else begin
			since <= fall ? 0 : since + 1;
			drive_high <= 1'b0;
			if (fall) begin
				txa <= txn > 0;
				txb <= txw[15];
				drive_low <= txn > 0 && !txw[15];
				if (txn > 0) begin
					txw <= txw << 1;
					txn <= txn - 1;
				end
				// host that ignores the wait, or an acknowledge
				if (need > 0 && (acked ? since >= need : since < need + 14))
					wait_errs <= wait_errs + 1;
				need <= 0;
				acked <= 1'b0;
			end else if (since == TIMEOUT_CYCLES - 1) begin
				bitn <= 0;
				nin <= 0;
				txn <= 0;
			end
			if (txa && since == (txb ? 4 : 11)) begin
				drive_low <= 1'b0;
				drive_high <= 1'b1;
			end
			if (rdw && ack_enable && need > 0 && since == 20) begin
				drive_low <= 1'b1;
				acked <= 1'b1;
				ackc <= 4;
			end
			if (ackc > 0) begin
				ackc <= ackc - 1;
				if (ackc == 1) begin
					drive_low <= 1'b0;
					drive_high <= 1'b1;
				end
			end
			if (!txa && since == 7) begin
				b = {sh[6:0], line};
				sh <= b;
				bitn <= (bitn + 1) % BITS_PER_BYTE;
				if (bitn == 7) begin
					cn = {col[23:0], b};
					ov = nin == 0 ? b : op;
					tot = ov[7] ? (ov[4] ? (ov[6] ? 5 : 3) : (ov[6] ? 3 : 1)) : 1;
					if (nin == 0)
						op <= b;
					col <= cn;
					nin <= nin + 1;
					if (nin + 1 == tot) begin
						nin <= 0;
						rdw <= ov[7] && !ov[4];
						case ({ov[7:6], ov[4]})
						3'b110: begin
							txw <= mem[cn[8:1]];
							txn <= 16;
							need <= WAIT_HW_RD;
						end
						3'b111: begin
							mem[cn[24:17]] <= cn[15:0];
							need <= WAIT_HW_WR;
						end
						3'b100: begin
							txw <= fw_word;
							txn <= 16;
							need <= WAIT_FW_RD;
						end
						3'b101: begin
							fw_word <= cn[15:0];
							need <= WAIT_FW_WR;
						end
						default: need <= WAIT_GO;
						endcase
					end
				end
			end
		end
	end
endmodule // dbgh_dev_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import dbgh_pkg::*;
	localparam logic [7:0] OP_HW_RD = 8'hc4;
	localparam logic [7:0] OP_HW_WR = 8'hd4;
	localparam logic [7:0] OP_FW_RD = 8'ha4;
	localparam logic [7:0] OP_FW_WR = 8'hb4;
	localparam logic [7:0] OP_STEP = 8'h10;
	localparam logic [7:0] OP_GO = 8'h08;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid, cmd_ready, ack_enable, special_mode, tgt_reset_n;
	logic resp_valid, pin_out, pin_oe, tb_low, dev_low, dev_high, mode_sp;
	dbgh_kind_t cmd_kind;
	logic [7:0] cmd_opcode;
	logic [15:0] cmd_addr, cmd_wdata, resp_data, a, d, got;
	logic [15:0] shadow [256];
	int werr;
	int err_count = 0;
	int num_checks = 0;
	// open-drain line with pull-up
	wire line = !((pin_oe && !pin_out) || dev_low || tb_low);
	always #2.5 clk_sys = !clk_sys;
	initial #1.1 forever #15 clk_link = !clk_link;
	dbgh_host i_dut (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_link(clk_link),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready),
		.cmd_kind(cmd_kind),
		.cmd_opcode(cmd_opcode),
		.cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata),
		.ack_enable(ack_enable),
		.special_mode(special_mode),
		.tgt_reset_n(tgt_reset_n),
		.resp_valid(resp_valid),
		.resp_data(resp_data),
		.debug_serial_pin_in(line),
		.debug_serial_pin_out(pin_out),
		.debug_serial_pin_oe(pin_oe)
	);
	dbgh_dev_model i_dev (
		.clk_link(clk_link),
		.tgt_reset_n(tgt_reset_n),
		.ack_enable(ack_enable),
		.line(line),
		.drive_low(dev_low),
		.drive_high(dev_high),
		.mode_special(mode_sp),
		.wait_errs(werr)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check16(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: word %h want %h", $time, g, e);
		end
	endtask
	task automatic check_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: flag %b want %b", $time, g, e);
		end
	endtask
	function automatic logic [15:0] exp_word(input logic [15:0] adr);
		return shadow[adr[8:1]];
	endfunction
	task automatic run(input dbgh_kind_t k, input logic [7:0] op,
		input logic [15:0] ad, input logic [15:0] wd, output logic [15:0] r);
		int n;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_opcode <= op;
		cmd_addr <= ad;
		cmd_wdata <= wd;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (resp_valid !== 1'b1 && n < 40000);
		check_bit(n < 40000, 1'b1);
		r = resp_data;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{cmd_valid, ack_enable, special_mode, tb_low, tgt_reset_n} = 5'h00;
		cmd_kind = K_HW_READ;
		cmd_opcode = 8'h00;
		cmd_addr = 16'h0000;
		cmd_wdata = 16'h0000;
		for (int i = 0; i < 256; i++)
			shadow[i] = 16'h0000;
		void'($urandom(44));
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk_sys);
			tgt_reset_n <= 1'b0;
			special_mode <= s[0];
			repeat (200) @(posedge clk_sys);
			tgt_reset_n <= 1'b1;
			repeat (200) @(posedge clk_sys);
			check_bit(mode_sp, s[0]);
		end
		// stray partial byte, then silence past the device timeout
		repeat (3) begin
			@(posedge clk_link);
			tb_low <= 1'b1;
			repeat (4) @(posedge clk_link);
			tb_low <= 1'b0;
			repeat (12) @(posedge clk_link);
		end
		repeat (TIMEOUT_CYCLES + 40) @(posedge clk_link);
		for (int i = 0; i < 4; i++) begin
			a = 16'($urandom);
			d = 16'($urandom);
			ack_enable <= i >= 2;
			run(K_HW_WRITE, OP_HW_WR, a, d, got);
			shadow[a[8:1]] = d;
			run(K_HW_READ, OP_HW_RD, a ^ 16'h0001, 16'h0000, got);
			check16(got, exp_word(a ^ 16'h0001));
			d = 16'($urandom);
			run(K_FW_WRITE, OP_FW_WR, 16'h0000, d, got);
			run(K_FW_READ, OP_FW_RD, 16'h0000, 16'h0000, got);
			check16(got, d);
			run(K_FW_CTRL, i[0] ? OP_STEP : OP_GO, 16'h0000, 16'h0000, got);
		end
		repeat (300) @(posedge clk_sys);
		check16(16'(werr), 16'h0000);
		finish_test();
	end
	initial begin
		#480us;
		err_count++;
		$display("unexpected at %0t: run did not finish", $time);
		finish_test();
	end
endmodule // tb_top
